// File: src/bbt_core.sv
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module bbt_core
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // AXI4-Lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Pins
    input  wire logic        enable_in,
    input  wire logic        dir_in,
    input  wire logic [2:0]  hall_in,
    input  wire logic        sense_trip,
    input  wire logic        zero_current,
    output bbt_pkg::bbt_gate_t gate,
    output logic             dir_out,
    output logic             tach_pull
);
    // Pin synchronisation
    logic [5:0] pins_s;
    logic       en_s, dir_s, trip_s, zero_s;
    logic [2:0] hall_s;

    bbt_sync #(.W(6)) u_sync
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .d       ({enable_in, dir_in, hall_in, sense_trip}),
        .q       (pins_s)
    );
    assign en_s   = pins_s[5];
    assign dir_s  = pins_s[4];
    assign hall_s = pins_s[3:1];
    assign trip_s = pins_s[0];

    bbt_sync #(.W(1)) u_zsync
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .d       (zero_current),
        .q       (zero_s)
    );

    // Register bus state
    logic [3:0]  ctrl_r, ctrl_nxt;
    logic        aw_r, aw_nxt, w_r, w_nxt;
    logic [3:0]  awa_r, awa_nxt;
    logic [31:0] wd_r, wd_nxt;
    logic        bv_r, bv_nxt, rv_r, rv_nxt;
    logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic        awrdy_r, wrdy_r, arrdy_r;

    // Motor state
    bbt_pkg::bbt_phase_t ph_r, ph_nxt;
    logic [6:0]  cnt_r, cnt_nxt;
    logic [7:0]  div_r, div_nxt;
    logic        en_q_r, dir_q_r;
    logic [2:0]  hall_q_r;
    logic        tach_r, tach_nxt;
    logic        rect_r, rect_nxt;
    bbt_pkg::bbt_gate_t gate_r, gate_nxt;
    logic        dir_r;
    logic        osc_tick, blank_act;
    logic        sr_en, brake, blank_sel, ext_pwm;
    logic [6:0]  blank_len;

    assign sr_en     = ctrl_r[bbt_pkg::CTRL_SR_BIT];
    assign brake     = ctrl_r[bbt_pkg::CTRL_BRAKE_BIT];
    assign blank_sel = ctrl_r[bbt_pkg::CTRL_BLANK_BIT];
    assign ext_pwm   = ctrl_r[bbt_pkg::CTRL_EXT_BIT];
    assign osc_tick  = (div_r == 8'h00);
    assign blank_len = blank_sel ? bbt_pkg::BLANK_LONG
                                 : bbt_pkg::BLANK_SHORT;
    assign blank_act = (ph_r == bbt_pkg::BBT_BLANK);

    // AXI4-Lite next state
    always_comb
    begin
        aw_nxt   = aw_r;
        w_nxt    = w_r;
        awa_nxt  = awa_r;
        wd_nxt   = wd_r;
        bv_nxt   = bv_r;
        br_nxt   = br_r;
        rv_nxt   = rv_r;
        rr_nxt   = rr_r;
        rd_nxt   = rd_r;
        ctrl_nxt = ctrl_r;
        if (s_axi_awvalid && awrdy_r)
        begin
            aw_nxt  = 1'b1;
            awa_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wrdy_r)
        begin
            w_nxt  = 1'b1;
            wd_nxt = s_axi_wdata;
        end
        if (aw_r && w_r)
        begin
            aw_nxt = 1'b0;
            w_nxt  = 1'b0;
            bv_nxt = 1'b1;
            if (awa_r == bbt_pkg::CTRL_ADDR)
            begin
                br_nxt = bbt_pkg::RESP_OKAY;
                if (s_axi_wstrb[0])
                    ctrl_nxt = wd_r[3:0];
            end
            else if (awa_r == bbt_pkg::STAT_ADDR)
                br_nxt = bbt_pkg::RESP_OKAY;
            else
                br_nxt = bbt_pkg::RESP_SLVERR;
        end
        if (bv_r && s_axi_bready)
            bv_nxt = 1'b0;
        if (rv_r && s_axi_rready)
            rv_nxt = 1'b0;
        else if (s_axi_arvalid && arrdy_r)
        begin
            rv_nxt = 1'b1;
            rr_nxt = bbt_pkg::RESP_OKAY;
            if (s_axi_araddr == bbt_pkg::CTRL_ADDR)
                rd_nxt = {28'h0000000, ctrl_r};
            else if (s_axi_araddr == bbt_pkg::STAT_ADDR)
                rd_nxt = {26'h0000000, ph_r, tach_r,
                          rect_r, gate_r.source_on, blank_act};
            else
            begin
                rd_nxt = 32'h00000000;
                rr_nxt = bbt_pkg::RESP_SLVERR;
            end
        end
    end

    // Motor control next state
    always_comb
    begin
        ph_nxt   = ph_r;
        cnt_nxt  = cnt_r;
        div_nxt  = osc_tick ? (bbt_pkg::OSC_DIV - 8'h01) : div_r - 8'h01;
        tach_nxt = tach_r;
        if (hall_s != hall_q_r)
            tach_nxt = ~tach_r;
        case (ph_r)
            bbt_pkg::BBT_ON:
            begin
                if (!en_s)
                    ph_nxt = bbt_pkg::BBT_OFF;
                else if (trip_s && !brake)
                begin
                    ph_nxt  = bbt_pkg::BBT_OFF;
                    cnt_nxt = bbt_pkg::OFF_TIME_COUNTS;
                end
            end
            bbt_pkg::BBT_OFF:
            begin
                if (en_s && cnt_r == 7'h00)
                begin
                    ph_nxt  = bbt_pkg::BBT_BLANK;
                    cnt_nxt = blank_len;
                end
                else if (osc_tick && cnt_r != 7'h00)
                    cnt_nxt = cnt_r - 7'h01;
            end
            bbt_pkg::BBT_BLANK:
            begin
                if (!en_s)
                begin
                    ph_nxt  = bbt_pkg::BBT_OFF;
                    cnt_nxt = 7'h00;
                end
                else if (cnt_r == 7'h00)
                    ph_nxt = bbt_pkg::BBT_ON;
                else if (osc_tick)
                    cnt_nxt = cnt_r - 7'h01;
            end
            default:
            begin
                ph_nxt  = bbt_pkg::BBT_OFF;
                cnt_nxt = 7'h00;
            end
        endcase
        // Direction change restarts blanking
        if (dir_s != dir_q_r && en_s)
        begin
            ph_nxt  = bbt_pkg::BBT_BLANK;
            cnt_nxt = blank_len;
        end
        // Rectify during decay until zero current seen
        rect_nxt = sr_en && (ph_r == bbt_pkg::BBT_OFF) &&
                   !zero_s && !ext_pwm_fast(ext_pwm, en_s);
        gate_nxt.source_on = !brake && (ph_r != bbt_pkg::BBT_OFF);
        gate_nxt.sink_on   = !brake &&
                             (en_s || ext_pwm);
        gate_nxt.all_sinks = brake;
        gate_nxt.rect_on   = rect_nxt && !brake;
    end

    // Fast external decay: sink chopped too, no rectification path
    function automatic logic ext_pwm_fast(input logic slow,
                                          input logic en);
        ext_pwm_fast = !slow && !en;
    endfunction

    // Registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r   <= bbt_pkg::CTRL_RESET;
            aw_r     <= 1'b0;
            w_r      <= 1'b0;
            awa_r    <= 4'h0;
            wd_r     <= 32'h00000000;
            bv_r     <= 1'b0;
            br_r     <= 2'h0;
            rv_r     <= 1'b0;
            rr_r     <= 2'h0;
            rd_r     <= 32'h00000000;
            ph_r     <= bbt_pkg::BBT_OFF;
            cnt_r    <= 7'h00;
            div_r    <= 8'h00;
            en_q_r   <= 1'b0;
            dir_q_r  <= 1'b0;
            hall_q_r <= 3'h0;
            tach_r   <= 1'b0;
            rect_r   <= 1'b0;
            gate_r   <= '0;
            dir_r    <= 1'b0;
        end
        else if (ce)
        begin
            ctrl_r   <= ctrl_nxt;
            aw_r     <= aw_nxt;
            w_r      <= w_nxt;
            awa_r    <= awa_nxt;
            wd_r     <= wd_nxt;
            bv_r     <= bv_nxt;
            br_r     <= br_nxt;
            rv_r     <= rv_nxt;
            rr_r     <= rr_nxt;
            rd_r     <= rd_nxt;
            ph_r     <= ph_nxt;
            cnt_r    <= cnt_nxt;
            div_r    <= div_nxt;
            en_q_r   <= en_s;
            dir_q_r  <= dir_s;
            hall_q_r <= hall_s;
            tach_r   <= tach_nxt;
            rect_r   <= rect_nxt;
            gate_r   <= gate_nxt;
            dir_r    <= dir_s;
        end
    end

    // Ready only while the slot is empty
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awrdy_r <= 1'b0;
            wrdy_r  <= 1'b0;
            arrdy_r <= 1'b0;
        end
        else if (ce)
        begin
            awrdy_r <= !aw_nxt && !bv_nxt;
            wrdy_r  <= !w_nxt && !bv_nxt;
            arrdy_r <= !rv_nxt;
        end
    end

    assign s_axi_awready = awrdy_r;
    assign s_axi_wready  = wrdy_r;
    assign s_axi_arready = arrdy_r;
    assign s_axi_bvalid  = bv_r;
    assign s_axi_bresp   = br_r;
    assign s_axi_rvalid  = rv_r;
    assign s_axi_rresp   = rr_r;
    assign s_axi_rdata   = rd_r;
    assign gate          = gate_r;
    assign dir_out       = dir_r;
    assign tach_pull     = tach_r;

    // Trip during a running blank count is ignored
    a_blank_mask: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && blank_act && en_s && trip_s && cnt_r != 7'h00
        |=> blank_act) else $error("trip seen in blank");
    // Brake drives all sinks next cycle
    a_brake_sinks: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && brake |=> gate_r.all_sinks && !gate_r.source_on)
        else $error("brake did not set sinks");
    // Tach follows each hall change
    a_tach_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && hall_s != hall_q_r |=> tach_r != $past(tach_r))
        else $error("tach missed hall edge");
    // No rectification with enable bit low
    a_rect_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !sr_en |=> !rect_r || $past(ce) == 1'b0 || sr_en)
        else $error("rectifier on while disabled");
    // Zero current stops rectification
    a_zero_stop: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && zero_s |=> !rect_r) else $error("rectify past zero");
    // Trip ends on period and loads 96 counts
    a_trip_off: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && ph_r == bbt_pkg::BBT_ON && en_s && trip_s && !brake
            && dir_s == dir_q_r
        |=> ph_r == bbt_pkg::BBT_OFF && cnt_r == bbt_pkg::OFF_TIME_COUNTS)
        else $error("trip not honoured");
    // Blank length loaded per select
    a_blank_len: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && ph_r == bbt_pkg::BBT_OFF && ph_nxt == bbt_pkg::BBT_BLANK
        |=> cnt_r == $past(blank_len)) else $error("bad blank length");
    // Enable chop leaves blanking
    a_chop_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        ce && blank_act && !en_s && dir_s == dir_q_r
        |=> ph_r == bbt_pkg::BBT_OFF) else $error("chop kept blank");
endmodule

// File: src/bbt_pkg.sv
package bbt_pkg;

    // Oscillator-count timing
    localparam logic [6:0] OFF_TIME_COUNTS  = 7'h60;  // 96 counts
    localparam logic [6:0] BLANK_SHORT      = 7'h06;  // 6 counts
    localparam logic [6:0] BLANK_LONG       = 7'h0C;  // 12 counts
    // Oscillator divider: osc tick every OSC_DIV aclk cycles
    localparam logic [7:0] OSC_DIV          = 8'h20;

    // Register map (byte addresses)
    localparam logic [3:0] CTRL_ADDR        = 4'h0;
    localparam logic [3:0] STAT_ADDR        = 4'h4;
    // Control register field positions
    localparam int CTRL_SR_BIT    = 0;
    localparam int CTRL_BRAKE_BIT = 1;
    localparam int CTRL_BLANK_BIT = 2;
    localparam int CTRL_EXT_BIT   = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0]
    {
        BBT_ON,
        BBT_OFF,
        BBT_BLANK
    } bbt_phase_t;

    // Bridge gate commands for one cycle
    typedef struct packed
    {
        logic       source_on;   // selected source driver on
        logic       sink_on;     // selected sink driver on
        logic       all_sinks;   // brake: three sinks on
        logic       rect_on;     // synchronous rectifier gate on
    } bbt_gate_t;

endpackage

// File: src/bbt_sync.sv
`timescale 1ns/10ps
// Three-stage synchroniser; change counts when stages two and three agree
module bbt_sync
#(
    parameter int W = 1
)
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_r, s2_r, s3_r, q_r;
    logic [W-1:0] q_nxt;

    // Filter: accept bits where stages two and three agree
    always_comb
    begin
        q_nxt = (s2_r & s3_r) | (q_r & (s2_r | s3_r));
    end

    // Shift chain
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r  <= '0;
        end
        else if (ce)
        begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r  <= q_nxt;
        end
    end

    assign q = q_r;
endmodule

// File: tb/bbt_motor_model.sv
`timescale 1ns/10ps
// Winding current and Hall sensor stand-in on the bridge side
module bbt_motor_model
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire bbt_pkg::bbt_gate_t gate,
    input  wire logic               force_trip,
    input  wire logic               step,
    output logic                    sense_trip,
    output logic                    zero_current,
    output logic [2:0]              hall_in
);
    // Hall codes in rotation order, three bits per position
    localparam logic [17:0] HALL_SEQ = 18'h2CC99;
    logic [9:0] cur_r;
    logic [2:0] pos_r;
    // Current ramps while the source conducts, decays otherwise
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cur_r <= 10'h000;
            pos_r <= 3'h0;
        end
        else
        begin
            if (gate.source_on && cur_r != 10'h3FF)
                cur_r <= cur_r + 10'h001;
            else if (!gate.source_on && cur_r != 10'h000)
                cur_r <= cur_r - 10'h001;
            if (step)
                pos_r <= (pos_r == 3'h5) ? 3'h0 : pos_r + 3'h1;
        end
    end
    // Comparator, zero detector and Hall lines
    assign sense_trip   = force_trip || cur_r == 10'h3FF;
    assign zero_current = cur_r == 10'h000;
    assign hall_in      = HALL_SEQ[3 * (5 - pos_r) +: 3];
endmodule

// File: tb/bldc_blank_brake_tach_sr_tb.sv
`timescale 1ns/10ps
// Bench for blanking, brake, tach and rectifier control
module bldc_blank_brake_tach_sr_tb;
    localparam int OSC = int'(bbt_pkg::OSC_DIV);
    logic        aclk = 1'h0;
    logic        aresetn = 1'h0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, ctl = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, rd_d;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rsp;
    logic        enable_in = 1'h0, force_trip = 1'h0, step = 1'h0;
    logic        dir_in = 1'h0;
    logic        sense_trip, zero_current, dir_out, tach_pull;
    logic [2:0]  hall_in, hall_prev = 3'h0;
    int          num_errors = 0, cmp_count = 0, hcnt = 0;
    bbt_pkg::bbt_gate_t gate;
    // Free-running 125 MHz clock
    always #4 aclk = ~aclk;
    // Device and bridge model
    bbt_core u_bbt_core
    (
        .aclk(aclk), .aresetn(aresetn), .ce(1'h1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .enable_in(enable_in), .dir_in(dir_in), .hall_in(hall_in),
        .sense_trip(sense_trip), .zero_current(zero_current), .gate(gate),
        .dir_out(dir_out), .tach_pull(tach_pull)
    );
    bbt_motor_model u_bbt_motor_model
    (
        .aclk(aclk), .aresetn(aresetn), .gate(gate),
        .force_trip(force_trip), .step(step), .sense_trip(sense_trip),
        .zero_current(zero_current), .hall_in(hall_in)
    );
    // Count Hall transitions at the pins
    always @(posedge aclk)
    begin
        if (hall_in !== hall_prev)
            hcnt <= hcnt + 1;
        hall_prev <= hall_in;
    end
    task automatic chk(input logic [31:0] g, e, input string m);
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask
    // Span since t in cycles, within one tick and some sync slack
    task automatic chk_span(input time t, input int e, input string m);
        int n;
        n = int'(($time - t) / 8);
        chk(32'(n > e - 40 && n < e + 40), 32'h1, m);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        for (int n = 0; n < 200; n++)
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'h0;
            if (wready)
                wvalid <= 1'h0;
            if (bvalid)
            begin
                rsp = bresp;
                break;
            end
        end
        bready <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        for (int n = 0; n < 200; n++)
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'h0;
            if (rvalid)
            begin
                rd_d = rdata;
                rsp  = rresp;
                break;
            end
        end
        rready <= 1'h0;
    endtask
    // Wait while the source gate holds level v
    task automatic hold(input logic v);
        for (int n = 0; n < 8000 && gate.source_on === v; n++)
            @(posedge aclk);
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        logic [31:0] d;
        logic [3:0]  s;
        logic        t0;
        int          h0;
        int          bl;
        time         t;
        void'($urandom(32'h9B12));
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        rd(bbt_pkg::CTRL_ADDR);
        chk(rd_d, 32'h0, "ctrl reset");
        rd(4'h8);
        chk(32'(rsp), 32'(bbt_pkg::RESP_SLVERR), "read resp");
        chk(rd_d, 32'h0, "read data");
        wr(4'hC, 32'hF, 4'hF);
        chk(32'(rsp), 32'(bbt_pkg::RESP_SLVERR), "write resp");
        for (int i = 0; i < 8; i++)
        begin
            d = $urandom();
            s = (i == 0) ? 4'hE : 4'($urandom());
            wr(bbt_pkg::CTRL_ADDR, d, s);
            if (s[0])
                ctl = d[3:0];
            rd(bbt_pkg::CTRL_ADDR);
            chk(rd_d, {28'h0, ctl}, "ctrl readback");
        end
        $display("register test done");
        // Chop with fast then slow decay, then brake
        for (int x = 0; x < 3; x++)
        begin
            d = (x == 0) ? 32'h0 : (x == 1) ? 32'h8 : 32'h2;
            wr(bbt_pkg::CTRL_ADDR, d, 4'h1);
            repeat (10) @(posedge aclk);
            chk(32'(gate.source_on), 32'h0, "chop source");
            if (x < 2)
                chk(32'(gate.sink_on), 32'(x), "chop sink");
            chk(32'(gate.all_sinks), 32'(x == 2), "brake sinks");
        end
        $display("decay and brake test done");
        repeat (3200) @(posedge aclk);
        // Blank length, trip, off time and rectifier per blank select
        for (int b = 0; b < 2; b++)
        begin
            bl = b ? int'(bbt_pkg::BLANK_LONG) : int'(bbt_pkg::BLANK_SHORT);
            wr(bbt_pkg::CTRL_ADDR, 32'(b * 5), 4'h1);
            repeat (10) @(posedge aclk);
            chk(32'(gate.all_sinks), 32'h0, "brake off");
            force_trip <= 1'h1;
            enable_in  <= 1'h1;
            hold(1'h0);
            t = $time;
            hold(1'h1);
            chk_span(t, bl * OSC, "first on");
            t = $time;
            repeat (8) @(posedge aclk);
            chk(32'(gate.rect_on), 32'(b), "rect in decay");
            for (int k = 0; k < 3000 && zero_current !== 1'h1; k++)
                @(posedge aclk);
            repeat (8) @(posedge aclk);
            chk(32'(gate.rect_on), 32'h0, "rect at zero");
            hold(1'h0);
            chk_span(t, int'(bbt_pkg::OFF_TIME_COUNTS) * OSC, "off");
            t = $time;
            hold(1'h1);
            chk_span(t, bl * OSC, "on after off");
            enable_in  <= 1'h0;
            force_trip <= 1'h0;
            repeat (3200) @(posedge aclk);
        end
        $display("blank and rectifier test done");
        // Random Hall steps against tach toggles
        h0 = hcnt;
        t0 = tach_pull;
        for (int i = 0; i < 12; i++)
        begin
            step <= 1'h1;
            @(posedge aclk);
            step <= 1'h0;
            repeat ($urandom_range(40, 8)) @(posedge aclk);
        end
        repeat (10) @(posedge aclk);
        chk(32'(tach_pull), 32'(t0 ^ 1'(hcnt - h0)), "tach");
        $display("tach test done");
        // Direction change while running restarts blanking
        enable_in <= 1'h1;
        repeat (500) @(posedge aclk);
        dir_in <= 1'h1;
        repeat (10) @(posedge aclk);
        chk(32'(dir_out), 32'h1, "dir out");
        rd(bbt_pkg::STAT_ADDR);
        chk(32'(rd_d[0]), 32'h1, "dir blank");
        chk(32'(rd_d[5:4]), 32'(bbt_pkg::BBT_BLANK), "dir phase");
        enable_in <= 1'h0;
        $display("direction test done");
        finish_test();
    end
    // Watchdog against a hung handshake
    initial
    begin
        repeat (60000) @(posedge aclk);
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule
